// [sacsr_pkg.sv]
// shared constants for the converter sequencer and its serial readout host
// assumes both ends run on ref_clk at the rate given by CLK_PERIOD_NS
package sacsr_pkg;

  // ************************************************************
  // helpers
  // ************************************************************
  // integer division rounded up, never below one
  function automatic int ceilDiv(input int num, input int den);
    int q;
    q = (num + den - 1) / den;
    return (q < 1) ? 1 : q;
  endfunction

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int DATA_BITS  = 10;
  localparam int SUB_BITS   = 2;
  localparam int FRAME_BITS = DATA_BITS + SUB_BITS;
  localparam int BIT_CNT_W  = 4;
  localparam int MSB_POS    = FRAME_BITS - 1;
  localparam int CODE_MSB   = DATA_BITS - 1;

  // ************************************************************
  // timing figures and derived cycle counts
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_FREQ_KHZ  = 4000;
  localparam int OSC_TOL_PCT   = 10;
  localparam int CONV_TIME_NS  = 3700;
  localparam int ACQ_TIME_NS   = 1400;
  localparam int PHASE_TIME_NS = 30;
  localparam int SCLK_MAX_KHZ  = 8000;
  localparam int PCT_FULL      = 100;
  localparam int NS_PER_MS     = 1000000;

  // nominal internal oscillator period in ref_clk cycles
  localparam int OSC_DIV_CYC   = NS_PER_MS / (OSC_FREQ_KHZ * CLK_PERIOD_NS);
  // longest conversion time, rounded down
  localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
  // oscillator ticks per conversion so that a slow oscillator still fits
  localparam int CONV_STEPS    = (CONV_CYC * PCT_FULL) /
                                 ((PCT_FULL + OSC_TOL_PCT) * OSC_DIV_CYC);
  // least times, rounded up
  localparam int ACQ_CYC       = ceilDiv(ACQ_TIME_NS, CLK_PERIOD_NS);
  localparam int PHASE_CYC     = ceilDiv(PHASE_TIME_NS, CLK_PERIOD_NS);
  localparam int SCLK_HALF_CYC = ceilDiv(NS_PER_MS, 2 * SCLK_MAX_KHZ * CLK_PERIOD_NS);

  localparam int HOST_CNT_W    = 16;

endpackage

// [sacsr_link_if.sv]
// three-wire link between converter sequencer and readout host
// assumes the bench joins both modports; the data line idles low when released
`timescale 1ns/10ps
interface sacsr_link_if;
  logic conversionStartPin;
  logic serialClk;
  logic dataOut;
  logic dataOutEn;
  logic dataLine;

  // wire level: released line reads low
  assign dataLine = dataOutEn & dataOut;

  modport device (
    input  conversionStartPin,
    input  serialClk,
    output dataOut,
    output dataOutEn
  );

  modport host (
    output conversionStartPin,
    output serialClk,
    input  dataLine
  );
endinterface

// [sacsr_device.sv]
// converter sequencer: start-pin decoding, timed conversion, serial shift-out
// assumes start pin and serial clock are asynchronous and arrive from the host
`timescale 1ns/10ps

// Functional notes
// RULE1: conversion paced by 4MHz internal oscillator, 3.7us
// RULE2: readout clock accepted from zero to 8MHz
// RULE3: ten result bits MSB first, two sub-bits
// RULE4: data output changes on serial clock falls only
// RULE5: host clocks whole frame before moving start pin
// RULE6: unipolar straight binary, bipolar two's complement
// RULE7: start pin low keeps device shut down
// RULE8: start rise powers up, data low, tracking
// RULE9: start fall holds, converts, presents MSB
// RULE10: single rise first; high-low-high selects second
// RULE11: host holds start high 1.4us acquiring
// RULE12: host gives twelve rising edges, samples rising
// RULE13: data output released after last sub-bit
// RULE14: byte host reads two bytes, mode zero
// RULE15: queued host reads 8 to 16 bits
// RULE16: short frame at next rise selects second
// RULE17: host holds pattern phases at least 30ns
module sacsr_device
  import sacsr_pkg::*;
#(
  parameter int OSC_DIV      = OSC_DIV_CYC,
  parameter int STEPS        = CONV_STEPS,
  parameter bit DIFFERENTIAL = 1'b0
)
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // link
  sacsr_link_if.device              link,
  // sampled input codes, offset binary
  input  wire logic [DATA_BITS-1:0] firstChannelCode,
  input  wire logic [DATA_BITS-1:0] secondChannelCode,
  input  wire logic [SUB_BITS-1:0]  subBitsIn,
  // status
  output logic                      poweredUp,
  output logic                      secondSelected,
  output logic                      convDone
);

  // ************************************************************
  // types and storage
  // ************************************************************
  typedef enum logic [1:0] {
    SD_SHUTDOWN = 2'b00,
    SD_TRACK    = 2'b01,
    SD_CONVERT  = 2'b10,
    SD_SHIFT    = 2'b11
  } sacsr_dstate_t;

  localparam int OSC_W  = $clog2(OSC_DIV + 1);
  localparam int STEP_W = $clog2(STEPS + 1);

  sacsr_dstate_t        state_reg, state_next;
  logic [OSC_W-1:0]     oscCnt_reg, oscCnt_next;
  logic [STEP_W-1:0]    stepCnt_reg, stepCnt_next;
  logic [FRAME_BITS-1:0] held_reg, held_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;
  logic [BIT_CNT_W-1:0] bitCnt_reg, bitCnt_next;
  logic                 frameDone_reg, frameDone_next;
  logic                 second_reg, second_next;
  logic                 dout_reg, dout_next;
  logic                 doutEn_reg, doutEn_next;
  logic                 powered_reg;
  logic                 done_reg;
  logic                 startS1_reg, startS2_reg, startS3_reg;
  logic                 sclkS1_reg, sclkS2_reg, sclkS3_reg;

  // ************************************************************
  // synchronisers and edge detection
  // ************************************************************
  // two flops per pin, third flop only for edges
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      startS1_reg <= 1'b0;
      startS2_reg <= 1'b0;
      startS3_reg <= 1'b0;
      sclkS1_reg  <= 1'b0;
      sclkS2_reg  <= 1'b0;
      sclkS3_reg  <= 1'b0;
    end
    else
    begin
      startS1_reg <= link.conversionStartPin;
      startS2_reg <= startS1_reg;
      startS3_reg <= startS2_reg;
      sclkS1_reg  <= link.serialClk;
      sclkS2_reg  <= sclkS1_reg;
      sclkS3_reg  <= sclkS2_reg;
    end
  end

  // edge strobes, sampled at 100MHz which covers an 8MHz serial clock
  wire startRise = startS2_reg & ~startS3_reg;
  wire startFall = ~startS2_reg & startS3_reg;
  wire sclkRise  = sclkS2_reg & ~sclkS3_reg; // RULE2
  wire sclkFall  = ~sclkS2_reg & sclkS3_reg; // RULE2

  // ************************************************************
  // result coding
  // ************************************************************
  // channel or polarity pick, MSB flip makes two's complement
  wire [DATA_BITS-1:0] rawCode  = second_reg ? secondChannelCode : firstChannelCode;
  wire                 flipMsb  = DIFFERENTIAL & second_reg; // RULE6
  wire [DATA_BITS-1:0] outCode  = {rawCode[CODE_MSB] ^ flipMsb, rawCode[CODE_MSB-1:0]};
  wire [FRAME_BITS-1:0] frameWord = {outCode, subBitsIn}; // RULE3
  wire                 oscTick  = (oscCnt_reg == OSC_W'(OSC_DIV - 1));
  wire                 lastStep = (stepCnt_reg == STEP_W'(STEPS - 1));
  wire                 lastRise = (bitCnt_reg == BIT_CNT_W'(FRAME_BITS - 1));
  wire                 allOut   = (bitCnt_reg == BIT_CNT_W'(FRAME_BITS));

  // ************************************************************
  // sequencer
  // ************************************************************
  // next state; a start rise overrides every state
  always_comb
  begin
    state_next     = state_reg;
    oscCnt_next    = oscCnt_reg;
    stepCnt_next   = stepCnt_reg;
    held_next      = held_reg;
    shift_next     = shift_reg;
    bitCnt_next    = bitCnt_reg;
    frameDone_next = frameDone_reg;
    second_next    = second_reg;
    dout_next      = dout_reg;
    doutEn_next    = doutEn_reg;
    if (startRise)
    begin
      state_next  = SD_TRACK;       // RULE8
      dout_next   = 1'b0;           // RULE8
      doutEn_next = 1'b1;
      second_next = ~frameDone_reg; // RULE10 RULE16
    end
    else
    begin
      case (state_reg)
        SD_SHUTDOWN:
        begin
          state_next = SD_SHUTDOWN; // RULE7
        end
        SD_TRACK:
        begin
          if (startFall)
          begin
            state_next     = SD_CONVERT; // RULE9
            held_next      = frameWord;
            frameDone_next = 1'b0;
            oscCnt_next    = '0;
            stepCnt_next   = '0;
          end
        end
        SD_CONVERT:
        begin
          oscCnt_next = oscTick ? '0 : oscCnt_reg + 1'b1; // RULE1
          if (oscTick)
          begin
            stepCnt_next = stepCnt_reg + 1'b1;
            if (lastStep)
            begin
              state_next  = SD_SHIFT; // RULE9
              shift_next  = held_reg;
              dout_next   = held_reg[MSB_POS]; // RULE9
              bitCnt_next = '0;
            end
          end
        end
        SD_SHIFT:
        begin
          if (sclkRise && !allOut)
          begin
            bitCnt_next = bitCnt_reg + 1'b1;
            if (lastRise)
            begin
              frameDone_next = 1'b1;
            end
          end
          if (sclkFall && bitCnt_reg != '0)
          begin
            if (allOut)
            begin
              doutEn_next = 1'b0;        // RULE13
              state_next  = SD_SHUTDOWN; // RULE7
            end
            else
            begin
              shift_next = {shift_reg[MSB_POS-1:0], 1'b0};
              dout_next  = shift_reg[MSB_POS-1]; // RULE4
            end
          end
        end
        default:
        begin
          state_next = SD_SHUTDOWN;
        end
      endcase
    end
  end

  // state and datapath registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= SD_SHUTDOWN; // RULE7
      oscCnt_reg    <= '0;
      stepCnt_reg   <= '0;
      held_reg      <= '0;
      shift_reg     <= '0;
      bitCnt_reg    <= '0;
      frameDone_reg <= 1'b1;
      second_reg    <= 1'b0;
      dout_reg      <= 1'b0;
      doutEn_reg    <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      oscCnt_reg    <= oscCnt_next;
      stepCnt_reg   <= stepCnt_next;
      held_reg      <= held_next;
      shift_reg     <= shift_next;
      bitCnt_reg    <= bitCnt_next;
      frameDone_reg <= frameDone_next;
      second_reg    <= second_next;
      dout_reg      <= dout_next;
      doutEn_reg    <= doutEn_next;
    end
  end

  // status flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      powered_reg <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      powered_reg <= (state_next == SD_TRACK) || (state_next == SD_CONVERT);
      done_reg    <= (state_reg == SD_CONVERT) && (state_next == SD_SHIFT);
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.dataOut    = dout_reg;
  assign link.dataOutEn  = doutEn_reg;
  assign poweredUp       = powered_reg;
  assign secondSelected  = second_reg;
  assign convDone        = done_reg;

endmodule

// [sacsr_host.sv]
// readout host: start-pin patterns, divided serial clock, frame capture
// assumes the device answers within the conversion wait; user drains a 2-deep buffer
`timescale 1ns/10ps
module sacsr_host
  import sacsr_pkg::*;
#(
  parameter int ACQ_CYCLES  = ACQ_CYC,
  parameter int PHASE_CYCLES = PHASE_CYC,
  parameter int WAIT_CYCLES = CONV_CYC,
  parameter int HALF_CYCLES = SCLK_HALF_CYC
)
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // link
  sacsr_link_if.host                 link,
  // conversion request
  input  wire logic                  startReq,
  input  wire logic                  startSecond,
  output logic                       hostReady,
  // received frames
  output logic                       frameValid,
  output logic [FRAME_BITS-1:0]      frameData,
  input  wire logic                  frameReady
);

  // ************************************************************
  // types and storage
  // ************************************************************
  typedef enum logic [2:0] {
    SH_IDLE   = 3'b000,
    SH_PREHI  = 3'b001,
    SH_PRELO  = 3'b010,
    SH_ACQ    = 3'b011,
    SH_CONV   = 3'b100,
    SH_CLKLO  = 3'b101,
    SH_CLKHI  = 3'b110
  } sacsr_hstate_t;

  sacsr_hstate_t          state_reg, state_next;
  logic [HOST_CNT_W-1:0]  cnt_reg, cnt_next;
  logic [BIT_CNT_W-1:0]   bits_reg, bits_next;
  logic [FRAME_BITS-1:0]  rx_reg, rx_next;
  logic                   start_reg, start_next;
  logic                   sclk_reg, sclk_next;
  logic                   push;
  logic [FRAME_BITS-1:0]  mem0_reg, mem0_next, mem1_reg, mem1_next;
  logic                   valid0_reg, valid0_next, valid1_reg, valid1_next;
  logic                   ready_reg;
  logic                   dS1_reg, dS2_reg;

  // ************************************************************
  // data line synchroniser
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dS1_reg <= 1'b0;
      dS2_reg <= 1'b0;
    end
    else
    begin
      dS1_reg <= link.dataLine;
      dS2_reg <= dS1_reg;
    end
  end

  // ************************************************************
  // sequence
  // ************************************************************
  // phase end detection for each timed stage
  function automatic logic cntAt(input logic [HOST_CNT_W-1:0] c, input int n);
    return c == HOST_CNT_W'(n - 1);
  endfunction

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    bits_next  = bits_reg;
    rx_next    = rx_reg;
    start_next = start_reg;
    sclk_next  = sclk_reg;
    push       = 1'b0;
    case (state_reg)
      SH_IDLE:
      begin
        cnt_next = '0;
        if (startReq && !valid1_reg)
        begin
          start_next = 1'b1;
          state_next = startSecond ? SH_PREHI : SH_ACQ; // RULE10
        end
      end
      SH_PREHI:
      begin
        if (cntAt(cnt_reg, PHASE_CYCLES))
        begin
          start_next = 1'b0; // RULE17
          cnt_next   = '0;
          state_next = SH_PRELO;
        end
      end
      SH_PRELO:
      begin
        if (cntAt(cnt_reg, PHASE_CYCLES))
        begin
          start_next = 1'b1; // RULE17
          cnt_next   = '0;
          state_next = SH_ACQ;
        end
      end
      SH_ACQ:
      begin
        if (cntAt(cnt_reg, ACQ_CYCLES))
        begin
          start_next = 1'b0; // RULE11
          cnt_next   = '0;
          state_next = SH_CONV;
        end
      end
      SH_CONV:
      begin
        if (cntAt(cnt_reg, WAIT_CYCLES))
        begin
          cnt_next   = '0;
          bits_next  = '0;
          state_next = SH_CLKLO;
        end
      end
      SH_CLKLO:
      begin
        if (cntAt(cnt_reg, HALF_CYCLES))
        begin
          sclk_next  = 1'b1; // RULE2
          rx_next    = {rx_reg[MSB_POS-1:0], dS2_reg}; // RULE12
          bits_next  = bits_reg + 1'b1;
          cnt_next   = '0;
          state_next = SH_CLKHI;
        end
      end
      SH_CLKHI:
      begin
        if (cntAt(cnt_reg, HALF_CYCLES))
        begin
          sclk_next = 1'b0;
          cnt_next  = '0;
          if (bits_reg == BIT_CNT_W'(FRAME_BITS))
          begin
            push       = 1'b1; // RULE5 RULE12
            state_next = SH_IDLE;
          end
          else
          begin
            state_next = SH_CLKLO;
          end
        end
      end
      default:
      begin
        state_next = SH_IDLE;
      end
    endcase
  end

  // ************************************************************
  // two-entry frame buffer, head in mem0
  // ************************************************************
  wire pop = frameReady & valid0_reg;

  always_comb
  begin
    mem0_next   = mem0_reg;
    mem1_next   = mem1_reg;
    valid0_next = valid0_reg;
    valid1_next = valid1_reg;
    if (pop)
    begin
      mem0_next   = mem1_reg;
      valid0_next = valid1_reg;
      valid1_next = 1'b0;
    end
    if (push)
    begin
      if (!valid0_next)
      begin
        mem0_next   = rx_reg;
        valid0_next = 1'b1;
      end
      else
      begin
        mem1_next   = rx_reg;
        valid1_next = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg  <= SH_IDLE;
      cnt_reg    <= '0;
      bits_reg   <= '0;
      rx_reg     <= '0;
      start_reg  <= 1'b0;
      sclk_reg   <= 1'b0;
      mem0_reg   <= '0;
      mem1_reg   <= '0;
      valid0_reg <= 1'b0;
      valid1_reg <= 1'b0;
      ready_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      bits_reg   <= bits_next;
      rx_reg     <= rx_next;
      start_reg  <= start_next;
      sclk_reg   <= sclk_next;
      mem0_reg   <= mem0_next;
      mem1_reg   <= mem1_next;
      valid0_reg <= valid0_next;
      valid1_reg <= valid1_next;
      ready_reg  <= (state_next == SH_IDLE) && !valid1_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign link.conversionStartPin = start_reg;
  assign link.serialClk          = sclk_reg;
  assign hostReady               = ready_reg;
  assign frameValid              = valid0_reg;
  assign frameData               = mem0_reg;

endmodule

// [sacsr_link_properties.sv]
// checker: timing relations on the three-wire link between the two ends
// assumes plain connections to the interface signals, ref_clk domain only
`timescale 1ns/10ps
module sacsr_link_properties
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link
  input wire logic conversionStartPin,
  input wire logic serialClk,
  input wire logic dataOut,
  input wire logic dataOutEn
);
  // ************************************************************
  // helper logic
  // ************************************************************
  logic [3:0] riseCnt_reg, riseCnt_next;
  logic       sclkQ_reg, pinQ_reg;
  logic       sclkRise, pinRise;

  // serial clock rises since the last start rise
  assign sclkRise     = serialClk & ~sclkQ_reg;
  assign pinRise      = conversionStartPin & ~pinQ_reg;
  assign riseCnt_next = pinRise ? 4'h0 :
                        (sclkRise && riseCnt_reg != 4'hF) ? riseCnt_reg + 4'h1 : riseCnt_reg;

  // edge history and counter
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      riseCnt_reg <= 4'h0;
      sclkQ_reg   <= 1'b0;
      pinQ_reg    <= 1'b0;
    end
    else
    begin
      riseCnt_reg <= riseCnt_next;
      sclkQ_reg   <= serialClk;
      pinQ_reg    <= conversionStartPin;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_inFrameFall;
    $fell(serialClk) && riseCnt_reg != 4'h0 && riseCnt_reg < 4'hC;
  endsequence
  sequence s_lastFall;
    $fell(serialClk) && riseCnt_reg == 4'hC;
  endsequence
  sequence s_sclkSettled;
    serialClk && $past(serialClk) && $past(serialClk, 2) && $past(serialClk, 3) &&
      $past(serialClk, 4);
  endsequence

  property p_riseDrivesLow;
    $rose(conversionStartPin) |-> ##[1:4] (dataOutEn && !dataOut);
  endproperty
  property p_enableNeedsRise;
    $rose(dataOutEn) |->
      ($past(conversionStartPin, 2) || $past(conversionStartPin, 3) || $past(conversionStartPin, 4));
  endproperty
  property p_stableWhileHigh;
    s_sclkSettled |-> $stable(dataOut);
  endproperty
  property p_lowDuringConvert;
    ($fell(conversionStartPin) && dataOutEn) |-> !dataOut [*4];
  endproperty
  property p_keepDuringFrame;
    s_inFrameFall |-> dataOutEn [*4];
  endproperty
  property p_releaseAfterLast;
    s_lastFall |-> ##[1:5] !dataOutEn;
  endproperty
  property p_pinStillInFrame;
    (riseCnt_reg != 4'h0 && riseCnt_reg < 4'hC) |-> !conversionStartPin;
  endproperty
  property p_sclkHalf;
    $rose(serialClk) |-> serialClk [*7];
  endproperty
  property p_phaseLow;
    $fell(conversionStartPin) |-> !conversionStartPin [*3];
  endproperty
  property p_phaseHigh;
    $rose(conversionStartPin) |-> conversionStartPin [*3];
  endproperty

  a_riseDrivesLow: assert property (p_riseDrivesLow)
    else $error("start rise did not drive data low");
  a_enableNeedsRise: assert property (p_enableNeedsRise)
    else $error("data enabled without a start rise");
  a_stableWhileHigh: assert property (p_stableWhileHigh)
    else $error("data changed while serial clock high");
  a_lowDuringConvert: assert property (p_lowDuringConvert)
    else $error("data not low during conversion");
  a_keepDuringFrame: assert property (p_keepDuringFrame)
    else $error("data released before twelve bits");
  a_releaseAfterLast: assert property (p_releaseAfterLast)
    else $error("data not released after last bit");
  a_pinStillInFrame: assert property (p_pinStillInFrame)
    else $error("start pin moved inside a frame");
  a_sclkHalf: assert property (p_sclkHalf)
    else $error("serial clock high phase too short");
  a_phaseLow: assert property (p_phaseLow)
    else $error("start pin low phase too short");
  a_phaseHigh: assert property (p_phaseHigh)
    else $error("start pin high phase too short");
endmodule

// [sacsr_tb_top.sv]
// bench: host and sequencer joined, plus a bench-driven second sequencer
// assumes shortened figures on the joined pair, ref_clk at 100MHz
`timescale 1ns/10ps
module sacsr_tb_top
  import sacsr_pkg::*;
;
  typedef struct packed {
    logic       sec;
    logic [9:0] c1;
    logic [9:0] c2;
    logic [1:0] sb;
    logic [11:0] exp;
  } sacsr_row_t;

  localparam sacsr_row_t ROWS [4] = '{
    '{1'b0, 10'h2A5, 10'h15A, 2'h1, 12'hA95},
    '{1'b1, 10'h2A5, 10'h15A, 2'h2, 12'h56A},
    '{1'b0, 10'h3FF, 10'h000, 2'h3, 12'hFFF},
    '{1'b1, 10'h3FF, 10'h000, 2'h0, 12'h000}};

  logic        ref_clk, rstn, startReq, startSecond, frameReady, hostReady, frameValid;
  logic [11:0] frameData, word;
  logic [9:0]  firstCode, secondCode;
  logic [1:0]  subBits;
  logic        poweredUp, secondSelected, convDone, poweredUp2, secondSelected2, convDone2;
  int          miscompares, n_checks, cycles;

  sacsr_link_if i_sacsr_link_if ();
  sacsr_link_if i_sacsr_link_if2 ();

  // joined pair
  sacsr_device #(.OSC_DIV(4), .STEPS(2)) i_sacsr_device (
    .ref_clk(ref_clk), .rstn(rstn), .link(i_sacsr_link_if),
    .firstChannelCode(firstCode), .secondChannelCode(secondCode), .subBitsIn(subBits),
    .poweredUp(poweredUp), .secondSelected(secondSelected), .convDone(convDone));
  sacsr_host #(.ACQ_CYCLES(10), .WAIT_CYCLES(20)) i_sacsr_host (
    .ref_clk(ref_clk), .rstn(rstn), .link(i_sacsr_link_if), .startReq(startReq),
    .startSecond(startSecond), .hostReady(hostReady), .frameValid(frameValid),
    .frameData(frameData), .frameReady(frameReady));
  // sequencer on the bench-driven link, bipolar coding when second is selected
  sacsr_device #(.DIFFERENTIAL(1'b1)) i_sacsr_device2 (
    .ref_clk(ref_clk), .rstn(rstn), .link(i_sacsr_link_if2),
    .firstChannelCode(firstCode), .secondChannelCode(secondCode), .subBitsIn(subBits),
    .poweredUp(poweredUp2), .secondSelected(secondSelected2), .convDone(convDone2));
  sacsr_link_properties i_sacsr_link_properties (
    .ref_clk(ref_clk), .rstn(rstn),
    .conversionStartPin(i_sacsr_link_if.conversionStartPin),
    .serialClk(i_sacsr_link_if.serialClk),
    .dataOut(i_sacsr_link_if.dataOut), .dataOutEn(i_sacsr_link_if.dataOutEn));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic request(input logic sec);
    for (int i = 0; i < 400 && hostReady !== 1'b1; i++) @(posedge ref_clk);
    startSecond <= sec;
    startReq    <= 1'b1;
    @(posedge ref_clk);
    startReq    <= 1'b0;
  endtask
  task automatic waitFrame;
    for (int i = 0; i < 400 && frameValid !== 1'b1; i++) @(posedge ref_clk);
  endtask
  // start pin pulse on the bench link, then bounded wait for the result
  task automatic tbConvert(input logic expSecond);
    int i;
    i_sacsr_link_if2.conversionStartPin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(secondSelected2, expSecond, "selection");
    i_sacsr_link_if2.conversionStartPin <= 1'b0;
    for (i = 0; i < CONV_CYC && convDone2 !== 1'b1; i++) @(posedge ref_clk);
    check(12'(i < CONV_CYC), 12'h001, "conversion time");
    check(poweredUp2, 1'b0, "shutdown after conversion");
  endtask
  // 160 ns serial clock, sampling each bit at the rise
  task automatic tbRead(input int n, output logic [11:0] w);
    w = 12'h000;
    for (int b = 0; b < n; b++)
    begin
      repeat (8) @(posedge ref_clk);
      i_sacsr_link_if2.serialClk <= 1'b1;
      w = {w[10:0], i_sacsr_link_if2.dataLine};
      repeat (8) @(posedge ref_clk);
      i_sacsr_link_if2.serialClk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk);
  endtask

  // ************************************************************
  // clock, timeout, main sequence
  // ************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end

  // scenarios
  initial
  begin
    {rstn, startReq, startSecond, frameReady, firstCode, secondCode, subBits} = '0;
    i_sacsr_link_if2.conversionStartPin = 1'b0;
    i_sacsr_link_if2.serialClk = 1'b0;
    repeat (2) @(posedge ref_clk);
    check({hostReady, i_sacsr_link_if.conversionStartPin, i_sacsr_link_if.dataOutEn,
      poweredUp, frameValid}, 12'h000, "reset state");
    rstn       <= 1'b1;
    frameReady <= 1'b1;
    $display("test reset done");
    for (int r = 0; r < 4; r++)
    begin
      firstCode  <= ROWS[r].c1;
      secondCode <= ROWS[r].c2;
      subBits    <= ROWS[r].sb;
      request(ROWS[r].sec);
      waitFrame();
      check(frameData, ROWS[r].exp, "frame word");
      check(secondSelected, ROWS[r].sec, "select");
      @(posedge ref_clk);
    end
    $display("test table done");
    // fill the buffer while the reader stalls, then drain it
    frameReady <= 1'b0;
    firstCode  <= 10'h001;
    subBits    <= 2'h2;
    request(1'b0);
    waitFrame();
    firstCode  <= 10'h200;
    subBits    <= 2'h1;
    request(1'b0);
    repeat (400) @(posedge ref_clk);
    check(hostReady, 1'b0, "full buffer refuses");
    startReq <= 1'b1;
    repeat (30) @(posedge ref_clk);
    check(i_sacsr_link_if.conversionStartPin, 1'b0, "no start while full");
    startReq   <= 1'b0;
    frameReady <= 1'b1;
    @(posedge ref_clk);
    check(frameData, 12'h006, "first buffered word");
    @(posedge ref_clk);
    check(frameData, 12'h801, "second buffered word");
    @(posedge ref_clk);
    check(frameValid, 1'b0, "buffer empty");
    $display("test buffer done");
    // bench-driven link: full frame, short frame, bipolar frame
    firstCode  <= 10'h155;
    secondCode <= 10'h0F0;
    subBits    <= 2'h3;
    tbConvert(1'b0);
    tbRead(12, word);
    check(word, 12'h557, "first channel frame");
    check(i_sacsr_link_if2.dataOutEn, 1'b0, "released after frame");
    tbConvert(1'b0);
    tbRead(5, word);
    check(i_sacsr_link_if2.dataOutEn, 1'b1, "held in short frame");
    tbConvert(1'b1);
    tbRead(8, word);
    check(word, 12'h0BC, "bipolar hi");
    tbRead(8, word);
    check(word, 12'h030, "bipolar lo");
    $display("test bench link done");
    results();
  end
endmodule
